// file: design/csl_pkg.sv
package csl_pkg;
   // Register byte addresses
   localparam logic [7:0] CSL_OFS_LOOP_STATUS = 8'h68; // Loop status word
   localparam logic [7:0] CSL_OFS_CS_LOW = 8'h6c; // Captured status bits 31..0
   localparam logic [7:0] CSL_OFS_DECODE = 8'h70; // Decoded classes
   // Field positions in the captured status block
   localparam int CSL_CH_HI = 23;
   localparam int CSL_CH_LO = 20;
   localparam int CSL_SRC_HI = 19;
   localparam int CSL_SRC_LO = 16;
   localparam int CSL_CAT_HI = 15;
   localparam int CSL_CAT_LO = 8;
   localparam int CSL_MODE_HI = 7;
   localparam int CSL_MODE_LO = 6;
   localparam int CSL_SMP_HI = 5;
   localparam int CSL_SMP_LO = 3;
   localparam int CSL_NONPCM_BIT = 1;
   // Loop status word bit positions
   localparam int CSL_LOCK_BIT = 8;
   localparam int CSL_TOUT_BIT = 4;
   // Reset values
   localparam logic [31:0] CSL_RST_CS = 32'h0000_0000;
   localparam logic [1:0] CSL_RST_RESP = 2'h0;
   // AXI responses
   localparam logic [1:0] CSL_RESP_OKAY = 2'h0;
   localparam logic [1:0] CSL_RESP_SLVERR = 2'h2;
   // Product group classes
   typedef enum logic [3:0] {
      CSL_CAT_GENERAL = 4'h0,
      CSL_CAT_LASER = 4'h1,
      CSL_CAT_DIGITAL = 4'h2,
      CSL_CAT_MAGNETIC = 4'h3,
      CSL_CAT_BCAST_VIDEO = 4'h4,
      CSL_CAT_BCAST_AUDIO = 4'h5,
      CSL_CAT_MUSICAL = 4'h6,
      CSL_CAT_ADC_NOCP = 4'h7,
      CSL_CAT_ADC_CP = 4'h8,
      CSL_CAT_SOLID = 4'h9,
      CSL_CAT_EXPERIMENT = 4'ha,
      CSL_CAT_RESERVED = 4'hf
   } csl_cat_t;
   // Audio sampling classes
   typedef enum logic [1:0] {
      CSL_SMP_NO_EMPH = 2'h0,
      CSL_SMP_EMPH_50_15 = 2'h1,
      CSL_SMP_NONPCM_DEF = 2'h2,
      CSL_SMP_RESERVED = 2'h3
   } csl_smp_t;
   // Loop condition classes
   typedef enum logic [1:0] {
      CSL_LOOP_OUT = 2'h0,
      CSL_LOOP_LOCKED = 2'h1,
      CSL_LOOP_TIMEOUT = 2'h2
   } csl_loop_t;
endpackage

// file: design/csl_decode.sv
`timescale 1ns/1ns
module csl_decode
   import csl_pkg::*;
(
   input wire logic [31:0] cs_bits,
   input wire logic loop_locked_flag,
   input wire logic oscillator_timeout_flag,
   output csl_cat_t cat_class,
   output csl_smp_t smp_class,
   output logic mode0,
   output csl_loop_t loop_class
);
   logic [7:0] cat; // Category code
   logic [2:0] smp; // Sampling code
   assign cat = cs_bits[CSL_CAT_HI:CSL_CAT_LO];
   assign smp = cs_bits[CSL_SMP_HI:CSL_SMP_LO];

   // Product group from the top three category bits
   always_comb begin
      cat_class = CSL_CAT_RESERVED;
      unique case (cat[7:5])
         3'h4: cat_class = CSL_CAT_LASER;
         3'h2: cat_class = CSL_CAT_DIGITAL;
         3'h6: cat_class = CSL_CAT_MAGNETIC;
         3'h1: cat_class = CSL_CAT_BCAST_VIDEO;
         3'h5: cat_class = CSL_CAT_MUSICAL;
         3'h7: cat_class = CSL_CAT_RESERVED;
         3'h3: begin
            // Subdivided group
            if (cat[4]) cat_class = CSL_CAT_BCAST_AUDIO;
            else if (!cat[3]) cat_class = CSL_CAT_ADC_NOCP;
            else cat_class = CSL_CAT_ADC_CP;
         end
         3'h0: begin
            // L bit ignored except for the all-zero general code
            if (cat == 8'h00) cat_class = CSL_CAT_GENERAL;
            else if (cat[4]) cat_class = CSL_CAT_SOLID;
            else if (cat[4:1] == 4'h1) cat_class = CSL_CAT_EXPERIMENT;
            else cat_class = CSL_CAT_RESERVED;
         end
      endcase
   end

   // Sampling depends on the sample-word type bit
   always_comb begin
      smp_class = CSL_SMP_RESERVED;
      if (!cs_bits[CSL_NONPCM_BIT]) begin
         if (smp == 3'h0) smp_class = CSL_SMP_NO_EMPH;
         else if (smp == 3'h1) smp_class = CSL_SMP_EMPH_50_15;
      end else if (smp == 3'h0) begin
         smp_class = CSL_SMP_NONPCM_DEF;
      end
   end

   // Mode 0 is the only defined mode
   assign mode0 = (cs_bits[CSL_MODE_HI:CSL_MODE_LO] == 2'h0);

   // Time-out dominates the lock flag
   always_comb begin
      if (oscillator_timeout_flag) loop_class = CSL_LOOP_TIMEOUT;
      else if (loop_locked_flag) loop_class = CSL_LOOP_LOCKED;
      else loop_class = CSL_LOOP_OUT;
   end
endmodule

// file: design/csl_top.sv
// Operation
// - Bits 23..20 read as channel number
// - Bits 19..16 read as source number
// - Source number is plain binary, zero don't-care
// - Bits 15..8 read as category code
// - Top three category bits pick product group
// - Group 011 subdivided by next bits
// - Group 000 general, memory, experimental, reserved
// - Bits 7..6 mode, only 00 defined
// - Linear PCM sampling codes decode pre-emphasis
// - Non-PCM sampling: 000 default, else reserved
// - Loop status word at 68H, bits 8,4
// - Time-out dominates lock in joint decode
`timescale 1ns/1ns
module csl_top
   import csl_pkg::*;
(
   input wire logic clk,
   input wire logic rst,
   input wire logic rx_channel_status_bit,
   input wire logic rx_bit_valid,
   input wire logic rx_block_start,
   input wire logic loop_locked_flag,
   input wire logic oscillator_timeout_flag,
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready
);
   // Pin synchronisers, two stages each
   logic [4:0] sync1_ff;
   logic [4:0] sync2_ff;
   logic [4:0] nxt_sync1;
   logic [4:0] nxt_sync2;
   logic s_bit, s_valid, s_start, s_lock, s_tout; // Synchronised levels
   logic valid_d_ff; // Previous valid, for edge detect
   logic nxt_valid_d;

   always_comb begin
      nxt_sync1 = {rx_channel_status_bit, rx_bit_valid, rx_block_start,
                   loop_locked_flag, oscillator_timeout_flag};
      nxt_sync2 = sync1_ff;
      nxt_valid_d = s_valid;
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         sync1_ff <= 5'h00;
         sync2_ff <= 5'h00;
         valid_d_ff <= 1'b0;
      end else begin
         sync1_ff <= nxt_sync1;
         sync2_ff <= nxt_sync2;
         valid_d_ff <= nxt_valid_d;
      end
   end

   assign {s_bit, s_valid, s_start, s_lock, s_tout} = sync2_ff;

   // Capture of the first 32 status bits of each block
   logic [31:0] shift_ff; // Bits being assembled, LSB first
   logic [5:0] cnt_ff; // Bits taken this block
   logic [31:0] cs_ff; // Last complete capture
   logic [31:0] nxt_shift;
   logic [5:0] nxt_cnt;
   logic [31:0] nxt_cs;
   logic take; // One pulse per received bit

   assign take = s_valid & ~valid_d_ff;

   // Bits arrive bit 0 first; the word is published only when complete so
   // software never sees a half-updated block
   always_comb begin
      nxt_shift = shift_ff;
      nxt_cnt = cnt_ff;
      nxt_cs = cs_ff;
      if (take) begin
         if (s_start) begin
            // Block start restarts assembly at bit 0
            nxt_shift = {s_bit, 31'h0000_0000};
            nxt_cnt = 6'h01;
         end else if (cnt_ff < 6'h20) begin
            nxt_shift = {s_bit, shift_ff[31:1]};
            nxt_cnt = cnt_ff + 6'h01;
         end
      end
      if (cnt_ff == 6'h20) begin
         nxt_cs = shift_ff;
         nxt_cnt = 6'h21; // Hold until next block start
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         shift_ff <= CSL_RST_CS;
         cnt_ff <= 6'h21;
         cs_ff <= CSL_RST_CS;
      end else begin
         shift_ff <= nxt_shift;
         cnt_ff <= nxt_cnt;
         cs_ff <= nxt_cs;
      end
   end

   // Field decode
   csl_cat_t cat_class;
   csl_smp_t smp_class;
   csl_loop_t loop_class;
   logic mode0;

   csl_decode u_decode (
      .cs_bits(cs_ff),
      .loop_locked_flag(s_lock),
      .oscillator_timeout_flag(s_tout),
      .cat_class(cat_class),
      .smp_class(smp_class),
      .mode0(mode0),
      .loop_class(loop_class)
   );

   // Read data per address
   function automatic logic [31:0] rd_word(input logic [7:0] addr);
      logic [31:0] w;
      w = 32'h0000_0000;
      unique case (addr)
         CSL_OFS_LOOP_STATUS: begin
            // Only the two flags; everything else zero
            w[CSL_LOCK_BIT] = s_lock;
            w[CSL_TOUT_BIT] = s_tout;
         end
         CSL_OFS_CS_LOW: w = cs_ff;
         CSL_OFS_DECODE: begin
            w[3:0] = cat_class;
            w[5:4] = smp_class;
            w[6] = mode0;
            w[9:8] = loop_class;
            w[15:12] = cs_ff[CSL_SRC_HI:CSL_SRC_LO];
            w[19:16] = cs_ff[CSL_CH_HI:CSL_CH_LO];
         end
         default: w = 32'h0000_0000;
      endcase
      return w;
   endfunction

   function automatic logic known(input logic [7:0] addr);
      return (addr == CSL_OFS_LOOP_STATUS) || (addr == CSL_OFS_CS_LOW) ||
             (addr == CSL_OFS_DECODE);
   endfunction

   // AXI4-Lite slave; all registers read-only, writes answered SLVERR
   logic aw_got_ff, w_got_ff, bvalid_ff, rvalid_ff;
   logic [1:0] bresp_ff, rresp_ff;
   logic [31:0] rdata_ff;
   logic nxt_aw_got, nxt_w_got, nxt_bvalid, nxt_rvalid;
   logic [1:0] nxt_bresp, nxt_rresp;
   logic [31:0] nxt_rdata;

   assign s_axi_awready = ~aw_got_ff & ~bvalid_ff;
   assign s_axi_wready = ~w_got_ff & ~bvalid_ff;
   assign s_axi_arready = ~rvalid_ff;

   // Read has no side effect: it only samples state
   always_comb begin
      nxt_aw_got = aw_got_ff | (s_axi_awvalid & s_axi_awready);
      nxt_w_got = w_got_ff | (s_axi_wvalid & s_axi_wready);
      nxt_bvalid = bvalid_ff;
      nxt_bresp = bresp_ff;
      nxt_rvalid = rvalid_ff;
      nxt_rresp = rresp_ff;
      nxt_rdata = rdata_ff;
      if (bvalid_ff && s_axi_bready) begin
         nxt_bvalid = 1'b0;
      end else if (nxt_aw_got && nxt_w_got && !bvalid_ff) begin
         // Write data is discarded
         nxt_bvalid = 1'b1;
         nxt_bresp = CSL_RESP_SLVERR;
         nxt_aw_got = 1'b0;
         nxt_w_got = 1'b0;
      end
      if (rvalid_ff && s_axi_rready) begin
         nxt_rvalid = 1'b0;
      end else if (s_axi_arvalid && s_axi_arready) begin
         nxt_rvalid = 1'b1;
         nxt_rdata = rd_word(s_axi_araddr);
         nxt_rresp = known(s_axi_araddr) ? CSL_RESP_OKAY : CSL_RESP_SLVERR;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         aw_got_ff <= 1'b0;
         w_got_ff <= 1'b0;
         bvalid_ff <= 1'b0;
         bresp_ff <= CSL_RST_RESP;
         rvalid_ff <= 1'b0;
         rresp_ff <= CSL_RST_RESP;
         rdata_ff <= CSL_RST_CS;
      end else begin
         aw_got_ff <= nxt_aw_got;
         w_got_ff <= nxt_w_got;
         bvalid_ff <= nxt_bvalid;
         bresp_ff <= nxt_bresp;
         rvalid_ff <= nxt_rvalid;
         rresp_ff <= nxt_rresp;
         rdata_ff <= nxt_rdata;
      end
   end

   assign s_axi_bvalid = bvalid_ff;
   assign s_axi_bresp = bresp_ff;
   assign s_axi_rvalid = rvalid_ff;
   assign s_axi_rresp = rresp_ff;
   assign s_axi_rdata = rdata_ff;
endmodule

// file: verification/csl_top_assertions.sv
`timescale 1ns/1ns
module csl_top_assertions
   import csl_pkg::*;
(
   input wire logic clk,
   input wire logic rst,
   input wire logic loop_locked_flag,
   input wire logic oscillator_timeout_flag,
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic [1:0] s_axi_rresp,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic [1:0] s_axi_bresp,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready
);
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   // Read taken at this edge
   wire logic go = s_axi_arvalid && s_axi_arready;
   wire logic [7:0] a = s_axi_araddr;
   // Flags calm long enough to cross the synchroniser
   sequence s_calm;
      ($stable(loop_locked_flag) && $stable(oscillator_timeout_flag))[*6];
   endsequence
   property p_lat; go |=> s_axi_rvalid; endproperty
   a_lat: assert property (p_lat) else $error("late read");
   property p_blk; s_axi_rvalid |-> !s_axi_arready; endproperty
   a_blk: assert property (p_blk) else $error("read overlap");
   property p_hold; s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
   endproperty
   a_hold: assert property (p_hold) else $error("read dropped");
   property p_werr; s_axi_bvalid |-> s_axi_bresp == CSL_RESP_SLVERR; endproperty
   a_werr: assert property (p_werr) else $error("write not refused");
   property p_bhold; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid; endproperty
   a_bhold: assert property (p_bhold) else $error("write answer dropped");
   property p_word; s_calm ##0 (go && a == CSL_OFS_LOOP_STATUS) |=> s_axi_rdata ==
      {23'h0, $past(loop_locked_flag), 3'h0, $past(oscillator_timeout_flag), 4'h0};
   endproperty
   a_word: assert property (p_word) else $error("bad status word");
   property p_loop; s_calm ##0 (go && a == CSL_OFS_DECODE) |=> s_axi_rdata[9:8] ==
      ($past(oscillator_timeout_flag) ? 2'h2 : {1'b0, $past(loop_locked_flag)});
   endproperty
   a_loop: assert property (p_loop) else $error("bad loop class");
   property p_bad; go && !(a inside {8'h68, 8'h6c, 8'h70}) |=>
      s_axi_rresp == CSL_RESP_SLVERR && s_axi_rdata == 32'h0;
   endproperty
   a_bad: assert property (p_bad) else $error("bad read accepted");
   // Main scenarios reached
   c_word: cover property (go && a == CSL_OFS_LOOP_STATUS);
   c_dec: cover property (go && a == CSL_OFS_DECODE);
   c_wr: cover property (s_axi_bvalid);
   c_rwait: cover property (s_axi_rvalid && !s_axi_rready);
endmodule
bind csl_top csl_top_assertions u_chk (.clk(clk), .rst(rst),
   .loop_locked_flag(loop_locked_flag), .oscillator_timeout_flag(oscillator_timeout_flag),
   .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
   .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
   .s_axi_rready(s_axi_rready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
   .s_axi_bready(s_axi_bready));

// file: verification/csl_status_src.sv
`timescale 1ns/1ns
module csl_status_src (
   input wire logic clk,
   output logic rx_channel_status_bit,
   output logic rx_bit_valid,
   output logic rx_block_start
);
   // Idle: no strobe
   initial begin
      rx_channel_status_bit = 1'b0;
      rx_bit_valid = 1'b0;
      rx_block_start = 1'b0;
   end
   // One block, bit 0 first; each bit held six clocks, strobe low three clocks then high three
   task automatic send(input logic [31:0] w);
      for (int i = 0; i < 32; i++) begin
         @(posedge clk);
         rx_channel_status_bit <= w[i];
         rx_block_start <= (i == 0);
         rx_bit_valid <= 1'b0;
         repeat (3) @(posedge clk);
         rx_bit_valid <= 1'b1;
         repeat (2) @(posedge clk);
      end
      @(posedge clk);
      rx_bit_valid <= 1'b0;
      // Released line must not keep the last bit
      rx_channel_status_bit <= ~w[31];
      rx_block_start <= 1'b0;
   endtask
endmodule

// file: verification/channel_status_and_lock_readout_bench.sv
`timescale 1ns/1ns
module channel_status_and_lock_readout_bench
   import csl_pkg::*;
;
   logic clk = 1'b0, rst = 1'b1, lock = 1'b0, tout = 1'b0;
   logic aw = 1'b0, wv = 1'b0, ar = 1'b0;
   logic [7:0] awa = 8'h00, ara = 8'h00, cats [14];
   logic [31:0] wd = 32'h0, rdat, d, w;
   logic awr, wr_r, bv, arr, rv, sb, sv, ss;
   logic brdy = 1'b0, rrdy = 1'b0; // Answer-side readies, raised late at random
   logic [1:0] br, rr, r;
   int miscompares = 0, comparisons = 0;
   csl_status_src src (.clk(clk), .rx_channel_status_bit(sb), .rx_bit_valid(sv),
      .rx_block_start(ss));
   csl_top DUT (.clk(clk), .rst(rst), .rx_channel_status_bit(sb), .rx_bit_valid(sv),
      .rx_block_start(ss), .loop_locked_flag(lock), .oscillator_timeout_flag(tout),
      .s_axi_awaddr(awa), .s_axi_awvalid(aw), .s_axi_awready(awr), .s_axi_wdata(wd),
      .s_axi_wstrb(4'hf), .s_axi_wvalid(wv), .s_axi_wready(wr_r), .s_axi_bresp(br),
      .s_axi_bvalid(bv), .s_axi_bready(brdy), .s_axi_araddr(ara), .s_axi_arvalid(ar),
      .s_axi_arready(arr), .s_axi_rdata(rdat), .s_axi_rresp(rr), .s_axi_rvalid(rv),
      .s_axi_rready(rrdy));
   // 10 MHz clock
   initial begin
      forever #50 clk = ~clk;
   end
   task automatic chk(input logic [31:0] s, input logic [31:0] e);
      comparisons++;
      if (s !== e) begin
         miscompares++;
         $display("wrong value t=%0t seen %h exp %h", $time, s, e);
      end
   endtask
   task automatic complete_run;
      $display("comparisons %0d miscompares %0d", comparisons, miscompares);
      if (miscompares == 0 && comparisons > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   // Read; request held until the edge that samples arready, data taken with rvalid
   task automatic rd(input logic [7:0] a);
      int n;
      n = 0;
      ara <= a;
      ar <= 1'b1;
      do @(posedge clk); while (!arr && ++n < 99);
      ar <= 1'b0;
      // Late rready now and then, so the slave must hold its answer
      repeat ($urandom % 3) @(posedge clk);
      rrdy <= 1'b1;
      do @(posedge clk); while (!rv && ++n < 99);
      rrdy <= 1'b0;
      if (n >= 99) miscompares++;
      if (n >= 99) complete_run();
      d = rdat;
      r = rr;
   endtask
   // Write; address and data released each when taken
   task automatic wr(input logic [7:0] a);
      int n;
      logic ta, tw;
      n = 0;
      awa <= a;
      wd <= $urandom;
      aw <= 1'b1;
      wv <= 1'b1;
      ta = 1'b0;
      tw = 1'b0;
      do begin
         @(posedge clk);
         if (aw && awr) ta = 1'b1;
         if (wv && wr_r) tw = 1'b1;
         if (ta) aw <= 1'b0;
         if (tw) wv <= 1'b0;
      end while (!(ta && tw) && ++n < 99);
      // Late bready now and then, so the slave must hold its answer
      repeat ($urandom % 3) @(posedge clk);
      brdy <= 1'b1;
      do @(posedge clk); while (!bv && ++n < 99);
      brdy <= 1'b0;
      if (n >= 99) miscompares++;
      if (n >= 99) complete_run();
      r = br;
   endtask
   // Expected product group class
   function automatic logic [3:0] cat_x(input logic [7:0] c);
      case (c[7:5])
         3'h4: return 4'h1;
         3'h2: return 4'h2;
         3'h6: return 4'h3;
         3'h1: return 4'h4;
         3'h5: return 4'h6;
         3'h3: return c[4] ? 4'h5 : (c[3] ? 4'h8 : 4'h7);
         3'h0: return c == 8'h0 ? 4'h0 : c[4] ? 4'h9 : (c[4:1] == 4'h1) ? 4'ha : 4'hf;
         default: return 4'hf;
      endcase
   endfunction
   // Expected decode word
   function automatic logic [31:0] dec_x(input logic [31:0] v);
      logic [1:0] s;
      s = v[1] ? (v[5:3] == 3'h0 ? 2'h2 : 2'h3) : (v[5:3] < 3'h2 ? {1'b0, v[3]} : 2'h3);
      return {12'h0, v[23:20], v[19:16], 4'h1, 1'b0, v[7:6] == 2'h0, s, cat_x(v[15:8])};
   endfunction
   initial begin
      cats = '{8'h00, 8'h80, 8'h40, 8'hc0, 8'h20, 8'ha0, 8'h70, 8'h64, 8'h68, 8'h10, 8'h03,
         8'h01, 8'h0c, 8'he0};
      w = $urandom(66878);
      repeat (16) @(posedge clk);
      rst <= 1'b0;
      rd(CSL_OFS_CS_LOW);
      chk(d, 32'h0);
      // All flag pairs; time-out wins over lock
      for (int i = 0; i < 4; i++) begin
         lock <= i[0];
         tout <= i[1];
         repeat (8) @(posedge clk);
         rd(CSL_OFS_LOOP_STATUS);
         chk(d, {23'h0, i[0], 3'h0, i[1], 4'h0});
         chk({30'h0, r}, {30'h0, CSL_RESP_OKAY});
         rd(CSL_OFS_DECODE);
         chk(d & 32'h300, {22'h0, i[1] ? 2'h2 : {1'b0, i[0]}, 8'h0});
      end
      lock <= 1'b1;
      tout <= 1'b0;
      // Category corners and every sampling code, then random blocks
      for (int i = 0; i < 24; i++) begin
         w = $urandom;
         if (i < 14) w[15:8] = cats[i];
         if (i < 16) w[5:1] = {i[2:0], w[2], i[3]};
         src.send(w);
         repeat (4) @(posedge clk);
         rd(CSL_OFS_CS_LOW);
         chk(d, w);
         rd(CSL_OFS_DECODE);
         chk(d, dec_x(w));
      end
      // Write refused, word unchanged; stray address 69H refused
      wr(CSL_OFS_LOOP_STATUS);
      chk({30'h0, r}, {30'h0, CSL_RESP_SLVERR});
      rd(CSL_OFS_LOOP_STATUS);
      chk(d, 32'h100);
      rd(8'h69);
      chk({r, d[29:0]}, {CSL_RESP_SLVERR, 30'h0});
      complete_run();
   end
endmodule
